//--- dv/bls_mem_model.sv
// Partner model: a small memory behind external width decode and byte-swap routing.
// Assumes the sizer's bus cycle ports; the bench picks the bus width and the answer delay.
`timescale 1ns/1ps
module bls_mem_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [1:0]  width,
  input  wire logic [1:0]  delay,
  input  wire logic        cyc_req,
  input  wire logic        cyc_wr,
  input  wire logic [29:0] word,
  input  wire logic [3:0]  sel_n,
  input  wire logic [31:0] wdata,
  output logic [31:0]      rdata,
  output logic             cyc_end,
  output logic             half_n,
  output logic             byte_n
);
  logic [31:0] mem [0:15];
  logic [31:0] m;
  logic [1:0]  wait_q;
  logic        halfword_address_bit;
  logic        low_byte_select_n;
  logic        high_byte_select_n;
  logic        byte_address_bit;
  logic [3:0]  dev_lanes;
  // Each byte holds its own address, so the bench can work out read data by itself.
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 32'h03020100 + 32'h04040404 * 32'(i);
  end
  // Width decode answers again in every cycle, extra cycles included.
  assign half_n = !width[0];
  assign byte_n = !width[1];
  // Outside decode: halfword bit with low and high byte selects; the byte address bit is
  // the low byte select itself, so one decoder serves both narrow widths.
  assign halfword_address_bit = sel_n[1:0] == 2'h3;
  assign low_byte_select_n    = halfword_address_bit ? sel_n[2] : sel_n[0];
  assign high_byte_select_n   = halfword_address_bit ? sel_n[3] : sel_n[1];
  assign byte_address_bit     = low_byte_select_n;
  // A narrow device answers only on the lanes that its decoded address reaches.
  assign dev_lanes = width[1] ? 4'(4'h1 << {halfword_address_bit, byte_address_bit}) :
                     width[0] ? 4'({2'h0, !high_byte_select_n, !low_byte_select_n} <<
                                   {halfword_address_bit, 1'b0}) : ~sel_n;
  assign m = {{8{dev_lanes[3]}}, {8{dev_lanes[2]}}, {8{dev_lanes[1]}}, {8{dev_lanes[0]}}};
  // Unaddressed lanes float, so they show the inverse of the stored byte, never a copy.
  assign rdata = (mem[word[3:0]] & m) | (~mem[word[3:0]] & ~m);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q  <= 2'h0;
      cyc_end <= 1'b0;
    end else if (cyc_req && !cyc_end && wait_q >= delay) begin
      cyc_end <= 1'b1;
      wait_q  <= 2'h0;
    end else begin
      cyc_end <= 1'b0;
      wait_q  <= (cyc_req && !cyc_end) ? wait_q + 2'h1 : 2'h0;
    end
  end
  always @(posedge clk) begin
    if (cyc_req && cyc_end && cyc_wr) begin
      for (int b = 0; b < 4; b++) begin
        if (dev_lanes[b]) mem[word[3:0]][8*b +: 8] <= wdata[8*b +: 8];
      end
    end
  end
endmodule

//--- dv/bls_sizer_test.sv
// Self-checking bench for the sizer: reads, writes, width mixes, lane order and spaces.
// Assumes the memory model answers every bus cycle after a delay the bench chooses.
`timescale 1ns/1ps
module bls_sizer_test;
  logic        clk = 1'b0;
  logic        rst_n, req_valid, req_ready, req_write, req_io, req_done, cyc_req, cyc_wr;
  logic        space_io, oe, cyc_end, half_n, byte_n, io_seen;
  logic [31:0] req_addr, req_wdata, rdata, lanes_out, lanes_in, rd;
  logic [29:0] word;
  logic [3:0]  sel_n;
  logic [1:0]  req_size, width, delay;
  logic [33:0] log_q [$];
  logic        f_done, f_cyc_req, f_cyc_wr, f_end;
  logic [31:0] f_rdata, f_out, f_in, f_rd;
  logic [29:0] f_word;
  logic [3:0]  f_sel_n;
  int          ncyc, f_ncyc, miscompares, tests_run;
  bls_sizer uut (.CLOCK(clk), .RST_B(rst_n), .REQ_VALID(req_valid), .REQ_READY(req_ready),
    .REQ_ADDR(req_addr), .REQ_SIZE(req_size), .REQ_WRITE(req_write), .REQ_IO(req_io),
    .REQ_WDATA(req_wdata), .REQ_DONE(req_done), .REQ_RDATA(rdata), .CYCLE_REQ(cyc_req),
    .WORD_ADDRESS(word), .BYTE_LANE_SELECT_N(sel_n), .CYCLE_WRITE(cyc_wr),
    .SPACE_IO(space_io), .DATA_LANES_OUT(lanes_out), .DATA_LANES_OE(oe),
    .DATA_LANES_IN(lanes_in), .CYCLE_END(cyc_end), .HALF_WIDTH_REQUEST_N(half_n),
    .BYTE_WIDTH_REQUEST_N(byte_n));
  bls_mem_model mem_u (.clk(clk), .rst_n(rst_n), .width(width), .delay(delay),
    .cyc_req(cyc_req), .cyc_wr(cyc_wr), .word(word), .sel_n(sel_n), .wdata(lanes_out),
    .rdata(lanes_in), .cyc_end(cyc_end), .half_n(half_n), .byte_n(byte_n));
  // Fixed build sees both width requests asserted and must ignore them.
  bls_sizer #(.DYN_SIZING(1'b0)) uut_fixed (.CLOCK(clk), .RST_B(rst_n),
    .REQ_VALID(req_valid), .REQ_READY(), .REQ_ADDR(req_addr), .REQ_SIZE(req_size),
    .REQ_WRITE(req_write), .REQ_IO(req_io), .REQ_WDATA(req_wdata), .REQ_DONE(f_done),
    .REQ_RDATA(f_rdata), .CYCLE_REQ(f_cyc_req), .WORD_ADDRESS(f_word),
    .BYTE_LANE_SELECT_N(f_sel_n), .CYCLE_WRITE(f_cyc_wr), .SPACE_IO(),
    .DATA_LANES_OUT(f_out), .DATA_LANES_OE(), .DATA_LANES_IN(f_in), .CYCLE_END(f_end),
    .HALF_WIDTH_REQUEST_N(1'b0), .BYTE_WIDTH_REQUEST_N(1'b0));
  bls_mem_model mem_f (.clk(clk), .rst_n(rst_n), .width(2'h0), .delay(delay),
    .cyc_req(f_cyc_req), .cyc_wr(f_cyc_wr), .word(f_word), .sel_n(f_sel_n), .wdata(f_out),
    .rdata(f_in), .cyc_end(f_end), .half_n(), .byte_n());
  always #50 clk = ~clk;
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [31:0] lm(input logic [3:0] s);
    return {{8{!s[3]}}, {8{!s[2]}}, {8{!s[1]}}, {8{!s[0]}}};
  endfunction
  // Bus cycles needed for one word's lanes at a given width code.
  function automatic int cyc(input logic [3:0] m, input logic [1:0] w);
    if (m == 4'h0) return 0;
    if (w == 2'h0) return 1;
    if (w[1]) return $countones(m);
    return int'(|m[1:0]) + int'(|m[3:2]);
  endfunction
  // Every finished bus cycle is logged; its lane pattern and write lanes are judged here.
  always @(posedge clk) begin
    if (cyc_req && cyc_end) begin
      ncyc++;
      log_q.push_back({word, sel_n});
      if (space_io) io_seen = 1'b1;
      chk(64'(!((~sel_n) inside {4'h5, 4'h9, 4'hA, 4'hB, 4'hD})), 64'h1);
      if (cyc_wr) chk(64'({lanes_out & ~lm(sel_n), oe}), 64'h1);
    end
    if (f_cyc_req && f_end) f_ncyc++;
    if (f_done === 1'b1) f_rd = f_rdata;
  end
  task automatic xfer(input logic [31:0] a, input logic [1:0] s, input logic w,
                      input logic [31:0] wd, input logic io);
    int n;
    ncyc = 0;
    f_ncyc = 0;
    f_rd = 32'hFFFFFFFF;
    log_q.delete();
    io_seen = 1'b0;
    req_addr <= a;
    req_size <= s;
    req_write <= w;
    req_wdata <= wd;
    req_io <= io;
    req_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 50);
    if (req_ready !== 1'b1) begin
      miscompares++;
      close_out;
    end
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (req_done !== 1'b1 && n < 100);
    rd = rdata;
    if (f_done === 1'b1) f_rd = f_rdata;
    if (n >= 100) begin
      miscompares++;
      close_out;
    end
  endtask
  task automatic t_reset;
    chk(64'({req_ready, cyc_req, req_done, sel_n, oe, word}),
        {26'h0, 1'b1, 1'b0, 1'b0, 4'hF, 1'b0, 30'h0});
    $display("test reset done, mismatches %0d", miscompares);
  endtask
  task automatic t_reads;
    logic [7:0]  m;
    logic [31:0] e;
    int          n;
    for (int w = 0; w < 4; w++) for (int s = 0; s < 3; s++) for (int a = 0; a < 4; a++) begin
      width <= 2'(w);
      delay <= 2'(a);
      n = (s == 2) ? 4 : s + 1;
      m = 8'((1 << n) - 1) << a;
      e = 32'h0;
      for (int k = 0; k < n; k++) e[8*k +: 8] = 8'(16 + a + k);
      xfer(32'(16 + a), 2'(s), 1'b0, 32'h0, 1'b0);
      chk(64'(rd), 64'(e));
      chk(64'(ncyc), 64'(cyc(m[3:0], 2'(w)) + cyc(m[7:4], 2'(w))));
      chk(64'({f_rd, 4'(f_ncyc)}), 64'({e, ((m[7:4] != 4'h0) ? 4'h2 : 4'h1)}));
    end
    $display("test reads done, mismatches %0d", miscompares);
  endtask
  task automatic t_order;
    logic [33:0] e [9];
    int          len [3];
    int          base;
    e = '{{30'h8, 4'h0}, {30'h8, 4'h3}, {30'h8, 4'h0}, {30'h8, 4'h1}, {30'h8, 4'h3},
          {30'h8, 4'h7}, {30'h9, 4'hE}, {30'h8, 4'h1}, {30'h8, 4'h3}};
    len = '{2, 4, 3};
    base = 0;
    for (int c = 0; c < 3; c++) begin
      width <= (c == 1) ? 2'h2 : 2'h1;
      xfer((c == 2) ? 32'h21 : 32'h20, 2'h2, 1'b0, 32'h0, 1'b0);
      chk(64'(log_q.size()), 64'(len[c]));
      for (int i = 0; i < len[c]; i++)
        chk(64'((i < log_q.size()) ? log_q[i] : '1), 64'(e[base + i]));
      base += len[c];
    end
    $display("test order done, mismatches %0d", miscompares);
  endtask
  task automatic t_write;
    for (int w = 0; w < 4; w++) begin
      width <= 2'(w);
      delay <= 2'(w);
      xfer(32'h31, 2'h2, 1'b1, 32'hA1B2C3D4 ^ 32'(w), 1'b0);
      width <= 2'(3 - w);
      xfer(32'h31, 2'h2, 1'b0, 32'h0, 1'b0);
      chk(64'(rd), 64'(32'hA1B2C3D4 ^ 32'(w)));
    end
    $display("test write done, mismatches %0d", miscompares);
  endtask
  task automatic t_io;
    width <= 2'h0;
    xfer(32'h12345678, 2'h0, 1'b0, 32'h0, 1'b1);
    chk(64'({rd, io_seen}), {31'h0, 32'h38, 1'b1});
    chk(64'(log_q[0]), 64'({30'h159E, 4'hE}));
    xfer(32'hFFFFFFFC, 2'h0, 1'b0, 32'h0, 1'b0);
    chk(64'({log_q[0], io_seen}), 64'({30'h3FFFFFFF, 4'hE, 1'b0}));
    $display("test io done, mismatches %0d", miscompares);
  endtask
  initial begin
    rst_n = 1'b0;
    {req_valid, req_write, req_io, io_seen} = 4'h0;
    {req_addr, req_wdata, rd} = 96'h0;
    {req_size, width, delay} = 6'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_reads;
    t_order;
    t_write;
    t_io;
    close_out;
  end
endmodule

//--- rtl/bls_lane_if.sv
// Carrier between the sequencer and the lane splitter.
// Assumes both ends sit in the same clock domain; the splitter is purely combinational.
`timescale 1ns/1ps
interface bls_lane_if;
  logic [3:0] sel;
  logic       half_req;
  logic       byte_req;
  logic [3:0] taken;
  logic [3:0] remaining;

  modport seq   (output sel, output half_req, output byte_req, input taken, input remaining);
  modport split (input sel, input half_req, input byte_req, output taken, output remaining);
endinterface

//--- rtl/bls_lane_split.sv
// Lane splitter: which asserted lanes one bus cycle really moves, and which are left over.
// Assumes the width requests arrive already gated by the sizing option.
`timescale 1ns/1ps
module bls_lane_split (
  bls_lane_if.split lif
);

  logic [3:0] lowest;

  always_comb begin
    lowest = lif.sel & 4'(~lif.sel + 4'h1);
    if (lif.byte_req) begin
      lif.taken = lowest; // see R10 see R12 see R18
    end else if (lif.half_req) begin
      lif.taken = lif.sel & (((lowest & bls_pkg::HALF_LOW) != bls_pkg::SEL_NONE) ?
                             bls_pkg::HALF_LOW : bls_pkg::HALF_HIGH); // see R11 see R18
    end else begin
      lif.taken = lif.sel;
    end
    // Low lanes go first, so what remains is always the upper part. see R21
    lif.remaining = lif.sel & ~lif.taken; // see R14 see R15
  end

endmodule

//--- rtl/bls_pkg.sv
// Package for the bus byte lane sizing block: sizes, lane masks, states and reset values.
// Assumes a 32-bit data bus carrying four byte lanes and a 30-bit word address.
package bls_pkg;

  localparam int unsigned LANES      = 4;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned WORD_W     = 30;

  // Operand length codes on the request port.
  localparam logic [1:0] SIZE_BYTE   = 2'h0;
  localparam logic [1:0] SIZE_HALF   = 2'h1;
  localparam logic [1:0] SIZE_DWORD  = 2'h2;

  // Programmed I/O space ends at 0000FFFFH, so only the low 14 word bits may be set.
  localparam logic [29:0] IO_WORD_MASK = 30'h00003FFF;

  localparam logic [3:0]  SEL_NONE    = 4'h0;
  localparam logic [3:0]  HALF_LOW    = 4'h3;
  localparam logic [3:0]  HALF_HIGH   = 4'hC;
  localparam logic [29:0] WORD_RESET  = 30'h00000000;
  localparam logic [31:0] DATA_RESET  = 32'h00000000;
  localparam logic [63:0] BUF_RESET   = 64'h0000000000000000;

  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_CYCLE = 1'b1
  } bls_state_t;

  // Expands an active-high lane select into a 32-bit byte mask.
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // Bytes covered by an operand of the given length, starting at lane zero.
  function automatic logic [7:0] size_mask(input logic [1:0] size);
    case (size)
      SIZE_HALF:  size_mask = 8'h03;
      SIZE_DWORD: size_mask = 8'h0F;
      default:    size_mask = 8'h01;
    endcase
  endfunction

  // True when no deasserted lane separates two asserted lanes.
  function automatic logic sel_contig(input logic [3:0] sel);
    sel_contig = !(sel inside {4'h5, 4'h9, 4'hA, 4'hB, 4'hD});
  endfunction

endpackage

//--- rtl/bls_sizer.sv
// Bus byte lane sizing sequencer: turns one operand request into bus cycles with lane selects.
// Assumes the bus handshake lives outside; CYCLE_END marks the edge on which a cycle finishes.
`timescale 1ns/1ps

// What this block does
// R1: Operands of one, two or four bytes at any alignment, in one or two full-width cycles.
// R2: Word address lines carry upper bits; four active-low lane selects carry the low part.
// R3: A lane select is asserted only for bytes in the cycle; lowest byte on lane zero.
// R4: Never assert two lane groups separated by a deasserted lane.
// R5: Memory space spans the full 32 bits; I/O space stops at 0000FFFFH.
// R6: Outside logic decodes lane selects into halfword bit and low and high byte selects.
// R7: Outside logic decodes the two low address bits; byte bit equals low byte select.
// R8: Both width requests are sampled in every bus cycle, so widths may mix freely.
// R9: Outside decode asserts half or byte width request for narrow devices only.
// R10: Both width requests asserted means an 8-bit bus.
// R11: Half-width request splits a transfer into two, or three when misaligned.
// R12: Byte-width request splits a 32-bit transfer into four byte cycles.
// R13: Outside logic repeats the width request in each extra cycle.
// R14: Extra cycles carry selects for the remaining bytes and keep the word address.
// R15: A single-lane pattern needs no further cycle under either width request.
// R16: Devices drive data on the addressed lanes.
// R17: Outside logic provides byte-swap routing for narrow devices.
// R18: Capture the lowest lane in byte cycles, its halfword in half cycles, else all.
// R19: Write data only on selected lanes; other lanes driven but never copies.
// R20: A build option drops dynamic sizing and ignores both width requests.
// R21: Under width requests the low-order bytes go first, higher ones after; the code runs a straddling operand's upper word first.
// R22: Split reads are assembled and reported only after the final cycle ends.
module bls_sizer #(
  parameter bit DYN_SIZING = 1'b1
) (
  input  wire logic        CLOCK,
  input  wire logic        RST_B,
  input  wire logic        REQ_VALID,
  output logic             REQ_READY,
  input  wire logic [31:0] REQ_ADDR,
  input  wire logic [1:0]  REQ_SIZE,
  input  wire logic        REQ_WRITE,
  input  wire logic        REQ_IO,
  input  wire logic [31:0] REQ_WDATA,
  output logic             REQ_DONE,
  output logic [31:0]      REQ_RDATA,
  output logic             CYCLE_REQ,
  output logic [29:0]      WORD_ADDRESS,
  output logic [3:0]       BYTE_LANE_SELECT_N,
  output logic             CYCLE_WRITE,
  output logic             SPACE_IO,
  output logic [31:0]      DATA_LANES_OUT,
  output logic             DATA_LANES_OE,
  input  wire logic [31:0] DATA_LANES_IN,
  input  wire logic        CYCLE_END,
  input  wire logic        HALF_WIDTH_REQUEST_N,
  input  wire logic        BYTE_WIDTH_REQUEST_N
);

  bls_pkg::bls_state_t state_q;
  logic [3:0]          sel_q;
  logic [3:0]          lo_sel_q;
  logic                at_hi_q;
  logic [29:0]         word_q;
  logic                write_q;
  logic                io_q;
  logic [1:0]          off_q;
  logic [63:0]         wbuf_q;
  logic [63:0]         rbuf_q;
  logic [31:0]         dout_q;
  logic [31:0]         rdata_q;
  logic                done_q;

  logic [7:0]          req_mask;
  logic [63:0]         req_wshift;
  logic                req_take;
  logic                cyc_end;
  logic                more_lanes;
  logic                last_end;
  logic [3:0]          sel_d;
  logic                at_hi_d;
  logic [63:0]         wsrc;
  logic [63:0]         rbuf_d;
  logic [31:0]         cap_mask;

  bls_lane_if lif ();

  bls_lane_split u_split (
    .lif (lif)
  );

  // Width requests are looked at on every cycle end, never latched across cycles.
  assign lif.sel      = sel_q;
  assign lif.half_req = DYN_SIZING && !HALF_WIDTH_REQUEST_N; // see R8 see R20
  assign lif.byte_req = DYN_SIZING && !BYTE_WIDTH_REQUEST_N; // see R8 see R10 see R20

  assign req_take   = REQ_VALID && (state_q == bls_pkg::ST_IDLE);
  assign req_mask   = 8'(bls_pkg::size_mask(REQ_SIZE) << REQ_ADDR[1:0]); // see R1
  assign req_wshift = 64'({32'h00000000, REQ_WDATA} << {REQ_ADDR[1:0], 3'h0});
  assign cyc_end    = (state_q == bls_pkg::ST_CYCLE) && CYCLE_END;
  assign more_lanes = lif.remaining != bls_pkg::SEL_NONE;
  assign last_end   = cyc_end && !more_lanes && !at_hi_q; // see R22

  // Next lane pattern. A straddling operand runs its upper word first, then the lower one.
  always_comb begin
    sel_d   = sel_q;
    at_hi_d = at_hi_q;
    if (req_take) begin
      at_hi_d = req_mask[7:4] != bls_pkg::SEL_NONE; // see R1
      sel_d   = at_hi_d ? req_mask[7:4] : req_mask[3:0];
    end else if (cyc_end && more_lanes) begin
      sel_d = lif.remaining; // see R14
    end else if (cyc_end && at_hi_q) begin
      sel_d   = lo_sel_q;
      at_hi_d = 1'b0;
    end else if (cyc_end) begin
      sel_d = bls_pkg::SEL_NONE; // see R3 see R15
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      state_q  <= bls_pkg::ST_IDLE;
      sel_q    <= bls_pkg::SEL_NONE;
      lo_sel_q <= bls_pkg::SEL_NONE;
      at_hi_q  <= 1'b0;
    end else begin
      sel_q   <= sel_d;
      at_hi_q <= at_hi_d;
      if (req_take) begin
        state_q  <= bls_pkg::ST_CYCLE;
        lo_sel_q <= req_mask[3:0];
      end else if (last_end) begin
        state_q <= bls_pkg::ST_IDLE;
      end
    end
  end

  // Word address. I/O cycles are folded into the 64 Kbyte port space.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      word_q  <= bls_pkg::WORD_RESET;
      write_q <= 1'b0;
      io_q    <= 1'b0;
      off_q   <= 2'h0;
    end else if (req_take) begin
      word_q  <= (REQ_ADDR[31:2] + 30'(at_hi_d)) &
                 (REQ_IO ? bls_pkg::IO_WORD_MASK : 30'h3FFFFFFF); // see R2 see R5
      write_q <= REQ_WRITE;
      io_q    <= REQ_IO;
      off_q   <= REQ_ADDR[1:0];
    end else if (cyc_end && !more_lanes && at_hi_q) begin
      word_q <= (word_q - 30'h00000001) &
                (io_q ? bls_pkg::IO_WORD_MASK : 30'h3FFFFFFF); // see R5
    end
  end

  // Write lanes. Unselected lanes are driven as zero so stale bytes never leak out.
  assign wsrc = req_take ? req_wshift : wbuf_q;

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      wbuf_q <= bls_pkg::BUF_RESET;
      dout_q <= bls_pkg::DATA_RESET;
    end else begin
      if (req_take) begin
        wbuf_q <= req_wshift;
      end
      dout_q <= (at_hi_d ? wsrc[63:32] : wsrc[31:0]) & bls_pkg::lane_mask(sel_d); // see R19
    end
  end

  // Read assembly across every cycle of the request.
  assign cap_mask = bls_pkg::lane_mask(lif.taken); // see R18

  always_comb begin
    rbuf_d = rbuf_q;
    if (cyc_end && !write_q) begin
      if (at_hi_q) begin
        rbuf_d[63:32] = (rbuf_q[63:32] & ~cap_mask) | (DATA_LANES_IN & cap_mask);
      end else begin
        rbuf_d[31:0] = (rbuf_q[31:0] & ~cap_mask) | (DATA_LANES_IN & cap_mask);
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      rbuf_q  <= bls_pkg::BUF_RESET;
      rdata_q <= bls_pkg::DATA_RESET;
      done_q  <= 1'b0;
    end else begin
      rbuf_q <= req_take ? bls_pkg::BUF_RESET : rbuf_d;
      done_q <= last_end; // see R22
      if (last_end && !write_q) begin
        rdata_q <= 32'(rbuf_d >> {off_q, 3'h0}); // see R22
      end
    end
  end

  assign REQ_READY          = state_q == bls_pkg::ST_IDLE;
  assign REQ_DONE           = done_q;
  assign REQ_RDATA          = rdata_q;
  assign CYCLE_REQ          = state_q == bls_pkg::ST_CYCLE;
  assign WORD_ADDRESS       = word_q;
  assign BYTE_LANE_SELECT_N = ~sel_q; // see R2 see R3
  assign CYCLE_WRITE        = write_q;
  assign SPACE_IO           = io_q;
  assign DATA_LANES_OUT     = dout_q;
  assign DATA_LANES_OE      = CYCLE_REQ && write_q; // see R19

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);

  sequence final_end_s;
    cyc_end && !more_lanes && !at_hi_q;
  endsequence

  sequence done_pulse_s;
    REQ_DONE ##1 !REQ_DONE;
  endsequence

  idle_sel_a: assert property (!CYCLE_REQ |-> BYTE_LANE_SELECT_N == 4'hF) // see R3
    else $error("Lane select asserted outside a bus cycle.");
  sel_contig_a: assert property (bls_pkg::sel_contig(~BYTE_LANE_SELECT_N)) // see R4
    else $error("Lane select pattern has a gap.");
  io_range_a: assert property (CYCLE_REQ && SPACE_IO |-> WORD_ADDRESS[29:14] == 16'h0000) // see R5
    else $error("I/O cycle beyond the port space.");
  byte_one_a: assert property (cyc_end && lif.byte_req |-> $onehot(lif.taken)) // see R10
    else $error("Byte width cycle moved more than one lane.");
  single_done_a: assert property (cyc_end && $onehot(sel_q) |-> !more_lanes) // see R15
    else $error("Extra cycle after a single lane pattern.");
  same_word_a: assert property (cyc_end && more_lanes |=> $stable(WORD_ADDRESS)
                                && BYTE_LANE_SELECT_N == ~$past(lif.remaining)) // see R14
    else $error("Extra cycle changed word or selects wrongly.");
  low_first_a: assert property (cyc_end && more_lanes |-> // see R21
                                lif.taken < (lif.remaining & 4'(~lif.remaining + 4'h1)))
    else $error("Higher lanes moved before lower ones.");
  write_lanes_a: assert property (DATA_LANES_OE |-> // see R19
                                  (DATA_LANES_OUT & ~bls_pkg::lane_mask(sel_q)) == 32'h0)
    else $error("Write data on an unselected lane.");
  done_final_a: assert property (final_end_s |=> done_pulse_s) // see R22
    else $error("Completion not reported after the final cycle.");
  done_cause_a: assert property (REQ_DONE |-> $past(last_end) && REQ_READY) // see R22
    else $error("Completion without a final cycle end.");
  fixed_bus_a: assert property (!DYN_SIZING && cyc_end |-> lif.taken == sel_q) // see R20
    else $error("Width request honoured in a fixed build.");

endmodule
